// ===== smc_ctrl.sv
// Sleep mode controller top: APB registers, sleep sequencer, wake
// qualification, post-wake halt and reset-during-sleep handling.
// Assumes the core pulses sleep_exec once per sleep instruction and
// that the interrupt controller presents enabled, pending requests.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module smc_ctrl
  import smc_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  // Core side
  input wire logic sleep_exec,
  input wire logic nvm_busy,
  output logic core_halt_ff,
  output logic irq_resume_ff,
  output logic sys_rst_ff,
  // Wake sources
  input wire logic irq_any,
  input wire logic async_pin_irq,
  input wire logic twi_match_irq,
  input wire logic rtc_irq,
  input wire logic rst_src_req,
  // Clock enables
  output logic cpu_clk_en_ff,
  output logic nvm_clk_en_ff,
  output logic intc_clk_en_ff,
  output logic evsys_clk_en_ff,
  output logic rtc_clk_en_ff,
  output logic [SMC_NPER-1:0] per_clk_en_ff
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == SMC_CTRL_OFF) || (a == SMC_PRR_OFF) ||
                (a == SMC_STAT_OFF) || (a == SMC_WCNT_OFF);
  endfunction : is_mapped

  function automatic logic mode_ok(input logic [2:0] m);
    mode_ok = (m == SMC_MODE_IDLE) || (m == SMC_MODE_PDOWN) ||
              (m == SMC_MODE_PSAVE) || (m == SMC_MODE_STDBY) ||
              (m == SMC_MODE_ESTDBY);
  endfunction : mode_ok

  // Which sources may wake the device in a given mode
  function automatic logic wake_ok(input logic [2:0] m, input logic irq,
                                   input logic apin, input logic twi,
                                   input logic rtc);
    case (m)
      SMC_MODE_IDLE: begin
        wake_ok = irq || apin || twi || rtc;
      end
      SMC_MODE_PDOWN, SMC_MODE_STDBY: begin
        wake_ok = apin || twi;
      end
      SMC_MODE_PSAVE, SMC_MODE_ESTDBY: begin
        wake_ok = apin || twi || rtc;
      end
      default: begin
        wake_ok = 1'b0;
      end
    endcase
  endfunction : wake_ok

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  smc_state_t state_ff;
  smc_state_t nxt_state;
  logic sen_ff;
  logic [2:0] mode_ff;
  logic [2:0] slp_mode_ff;
  logic [SMC_NPER-1:0] prr_ff;
  logic [1:0] cause_ff;
  logic rflag_ff;
  logic [15:0] wcnt_ff;
  logic [2:0] halt_cnt_ff;
  logic access;
  logic setup_ack;
  logic wr_fire;
  logic sleep_go;
  logic wake_hit;
  logic rst_in_sleep;
  logic [31:0] nxt_rdata;

  smc_gate_if gif ();

  // ----------------------------------------
  // APB handshake
  // ----------------------------------------
  // One wait state: ready rises on the first access cycle and the
  // transfer completes on the next edge.
  assign access = psel && penable;
  assign setup_ack = access && !pready_ff;
  assign wr_fire = access && pready_ff && pwrite && !pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= setup_ack;
      pslverr_ff <= setup_ack && !is_mapped(paddr);
    end
  end

  always_comb begin
    nxt_rdata = 32'h00000000;
    case (paddr)
      SMC_CTRL_OFF: begin
        nxt_rdata[SMC_CTRL_SEN_BIT] = sen_ff;
        nxt_rdata[SMC_CTRL_MODE_LSB +: 3] = mode_ff;
      end
      SMC_PRR_OFF: begin
        nxt_rdata[SMC_NPER-1:0] = prr_ff;
      end
      SMC_STAT_OFF: begin
        nxt_rdata[SMC_STAT_STATE_LSB +: 3] = state_ff;
        nxt_rdata[SMC_STAT_CAUSE_LSB +: 2] = cause_ff;
        nxt_rdata[SMC_STAT_MODE_LSB +: 3] = slp_mode_ff;
        nxt_rdata[SMC_STAT_RFLAG_BIT] = rflag_ff;
      end
      SMC_WCNT_OFF: begin
        nxt_rdata[15:0] = wcnt_ff;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (ce) begin
      if (setup_ack && !pwrite) begin
        prdata_ff <= nxt_rdata;
      end else if (!access) begin
        prdata_ff <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // A full reset taken from an enabled reset source returns the
  // control settings to their reset values as well.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sen_ff <= SMC_CTRL_RST[SMC_CTRL_SEN_BIT];
      mode_ff <= SMC_CTRL_RST[SMC_CTRL_MODE_LSB +: 3];
      prr_ff <= SMC_PRR_RST;
    end else if (ce) begin
      if (state_ff == SMC_ST_RST) begin
        sen_ff <= SMC_CTRL_RST[SMC_CTRL_SEN_BIT];
        mode_ff <= SMC_CTRL_RST[SMC_CTRL_MODE_LSB +: 3];
        prr_ff <= SMC_PRR_RST;
      end else if (wr_fire && paddr == SMC_CTRL_OFF) begin
        sen_ff <= pwdata[SMC_CTRL_SEN_BIT];
        mode_ff <= pwdata[SMC_CTRL_MODE_LSB +: 3];
      end else if (wr_fire && paddr == SMC_PRR_OFF) begin
        prr_ff <= pwdata[SMC_NPER-1:0];
      end
    end
  end

  // ----------------------------------------
  // Sleep sequencer
  // ----------------------------------------
  // Unknown mode codes make the sleep instruction a no-op.
  assign sleep_go = (state_ff == SMC_ST_ACT) && sleep_exec && sen_ff &&
                    mode_ok(mode_ff);
  assign wake_hit = wake_ok(slp_mode_ff, irq_any, async_pin_irq,
                            twi_match_irq, rtc_irq);
  assign rst_in_sleep = rst_src_req &&
                        (state_ff == SMC_ST_DRAIN || state_ff == SMC_ST_SLEEP);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SMC_ST_ACT: begin
        if (sleep_go) begin
          nxt_state = SMC_ST_DRAIN;
        end
      end
      SMC_ST_DRAIN: begin
        if (wake_hit) begin
          nxt_state = SMC_ST_HALT;
        end else if (!nvm_busy) begin
          nxt_state = SMC_ST_SLEEP;
        end
      end
      SMC_ST_SLEEP: begin
        if (wake_hit) begin
          nxt_state = SMC_ST_HALT;
        end
      end
      SMC_ST_HALT: begin
        if (halt_cnt_ff == 3'h0) begin
          nxt_state = SMC_ST_ACT;
        end
      end
      SMC_ST_RST: begin
        if (!rst_src_req) begin
          nxt_state = SMC_ST_HALT;
        end
      end
      default: begin
        nxt_state = SMC_ST_ACT;
      end
    endcase
    // An enabled reset source overrides everything else
    if (rst_src_req) begin
      nxt_state = SMC_ST_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SMC_ST_ACT;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Mode is latched at entry so a later register write cannot change
  // the wake rules of a sleep already in progress.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_mode_ff <= 3'h0;
    end else if (ce) begin
      if (sleep_go) begin
        slp_mode_ff <= mode_ff;
      end
    end
  end

  // ----------------------------------------
  // Post-wake halt
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_cnt_ff <= 3'h0;
    end else if (ce) begin
      if (nxt_state == SMC_ST_HALT && state_ff != SMC_ST_HALT) begin
        halt_cnt_ff <= SMC_HALT_CYCLES - 3'h1;
      end else if (state_ff == SMC_ST_HALT && halt_cnt_ff != 3'h0) begin
        halt_cnt_ff <= halt_cnt_ff - 3'h1;
      end
    end
  end

  // Only the wake cause is cleared on sleep entry: the core is only stalled
  // and its clocks gated, so all other register contents survive.
  // The interrupt controller then runs pending handlers by priority,
  // the waking one included, and the core returns past the sleep.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_halt_ff <= 1'b0;
      irq_resume_ff <= 1'b0;
      sys_rst_ff <= 1'b0;
    end else if (ce) begin
      core_halt_ff <= (nxt_state != SMC_ST_ACT);
      irq_resume_ff <= (state_ff == SMC_ST_HALT) &&
                       (nxt_state == SMC_ST_ACT) &&
                       (cause_ff == SMC_CAUSE_IRQ);
      sys_rst_ff <= (nxt_state == SMC_ST_RST);
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  // The halt that follows a reset keeps the reset cause, so no resume
  // pulse is sent. Flag is sticky, write one to clear; a new event in
  // the clear cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= SMC_CAUSE_NONE;
      rflag_ff <= 1'b0;
    end else if (ce) begin
      if (nxt_state == SMC_ST_RST) begin
        cause_ff <= SMC_CAUSE_RST;
      end else if (sleep_go) begin
        cause_ff <= SMC_CAUSE_NONE;
      end else if (nxt_state == SMC_ST_HALT && (state_ff == SMC_ST_DRAIN || state_ff == SMC_ST_SLEEP)) begin
        cause_ff <= SMC_CAUSE_IRQ;
      end
      if (rst_in_sleep) begin
        rflag_ff <= 1'b1;
      end else if (wr_fire && paddr == SMC_STAT_OFF &&
                   pwdata[SMC_STAT_RFLAG_BIT]) begin
        rflag_ff <= 1'b0;
      end
    end
  end

  // Wake-up counter, saturating; a write clears it unless a wake lands in the same cycle before saturation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_ff <= SMC_WCNT_RST;
    end else if (ce) begin
      if (state_ff != SMC_ST_HALT && nxt_state == SMC_ST_HALT &&
          wcnt_ff != 16'hFFFF) begin
        wcnt_ff <= wcnt_ff + 16'h0001;
      end else if (wr_fire && paddr == SMC_WCNT_OFF) begin
        wcnt_ff <= SMC_WCNT_RST;
      end
    end
  end

  // ----------------------------------------
  // Clock gating
  // ----------------------------------------
  assign gif.state = state_ff;
  assign gif.mode = slp_mode_ff;
  assign gif.prr = prr_ff;

  smc_gate u_gate (
    .pclk (pclk),
    .presetn (presetn),
    .ce (ce),
    .gi (gif.gate),
    .cpu_clk_en_ff (cpu_clk_en_ff),
    .nvm_clk_en_ff (nvm_clk_en_ff),
    .intc_clk_en_ff (intc_clk_en_ff),
    .evsys_clk_en_ff (evsys_clk_en_ff),
    .rtc_clk_en_ff (rtc_clk_en_ff),
    .per_clk_en_ff (per_clk_en_ff)
  );

endmodule : smc_ctrl
`default_nettype wire

// ===== smc_pkg.sv
// Package for the sleep mode controller: register map, field layout,
// reset values, sleep mode encodings, state encoding and timing counts.
// Assumes a 32-bit APB with byte addresses and one word per register.
package smc_pkg;

  // Register byte offsets
  localparam logic [7:0] SMC_CTRL_OFF = 8'h00;
  localparam logic [7:0] SMC_PRR_OFF = 8'h04;
  localparam logic [7:0] SMC_STAT_OFF = 8'h08;
  localparam logic [7:0] SMC_WCNT_OFF = 8'h0C;

  // Control register fields
  localparam int SMC_CTRL_SEN_BIT = 0;
  localparam int SMC_CTRL_MODE_LSB = 1;
  localparam logic [3:0] SMC_CTRL_RST = 4'h0;

  // Power reduction: one gate bit per peripheral
  localparam int SMC_NPER = 8;
  localparam logic [7:0] SMC_PRR_RST = 8'h00;

  // Status register fields
  localparam int SMC_STAT_STATE_LSB = 0;
  localparam int SMC_STAT_CAUSE_LSB = 4;
  localparam int SMC_STAT_MODE_LSB = 8;
  localparam int SMC_STAT_RFLAG_BIT = 12;
  localparam logic [15:0] SMC_WCNT_RST = 16'h0000;

  // Sleep mode encodings, three bits
  localparam logic [2:0] SMC_MODE_IDLE = 3'h1;
  localparam logic [2:0] SMC_MODE_PDOWN = 3'h2;
  localparam logic [2:0] SMC_MODE_PSAVE = 3'h3;
  localparam logic [2:0] SMC_MODE_STDBY = 3'h6;
  localparam logic [2:0] SMC_MODE_ESTDBY = 3'h7;

  // Wake cause codes
  localparam logic [1:0] SMC_CAUSE_NONE = 2'h0;
  localparam logic [1:0] SMC_CAUSE_IRQ = 2'h1;
  localparam logic [1:0] SMC_CAUSE_RST = 2'h2;

  // Core halt after wake-up, in cycles
  localparam logic [2:0] SMC_HALT_CYCLES = 3'h4;

  // Gray coded along active, drain, sleep, halt, active
  typedef enum logic [2:0] {
    SMC_ST_ACT = 3'h0,
    SMC_ST_DRAIN = 3'h1,
    SMC_ST_SLEEP = 3'h3,
    SMC_ST_HALT = 3'h2,
    SMC_ST_RST = 3'h6
  } smc_state_t;

endpackage : smc_pkg

// ===== smc_gate_if.sv
// Carrier between the sequencer and the clock gate unit.
// Assumes both ends share pclk.
`timescale 1ns/10ps
`default_nettype none
interface smc_gate_if;
  import smc_pkg::*;
  smc_state_t state;
  logic [2:0] mode;
  logic [SMC_NPER-1:0] prr;
  modport ctl (output state, output mode, output prr);
  modport gate (input state, input mode, input prr);
endinterface : smc_gate_if
`default_nettype wire

// ===== smc_gate.sv
// Clock gate unit: turns sequencer state, sleep mode and power
// reduction bits into registered clock enables for each domain.
// Assumes gating cells downstream take these enables glitch-free.
`timescale 1ns/10ps
`default_nettype none
module smc_gate
  import smc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // From sequencer
  smc_gate_if.gate gi,
  // Clock enables
  output logic cpu_clk_en_ff,
  output logic nvm_clk_en_ff,
  output logic intc_clk_en_ff,
  output logic evsys_clk_en_ff,
  output logic rtc_clk_en_ff,
  output logic [SMC_NPER-1:0] per_clk_en_ff
);

  logic slp;
  logic idle;
  logic rtc_keep;

  assign slp = (gi.state == SMC_ST_SLEEP);
  assign idle = (gi.mode == SMC_MODE_IDLE);
  // Save-type modes keep the real-time counter ticking
  assign rtc_keep = (gi.mode == SMC_MODE_PSAVE) || (gi.mode == SMC_MODE_ESTDBY);

  // ----------------------------------------
  // Enables
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en_ff <= 1'b1;
      nvm_clk_en_ff <= 1'b1;
      intc_clk_en_ff <= 1'b1;
      evsys_clk_en_ff <= 1'b1;
      rtc_clk_en_ff <= 1'b1;
      per_clk_en_ff <= '1;
    end else if (ce) begin
      cpu_clk_en_ff <= !slp;
      nvm_clk_en_ff <= !slp;
      intc_clk_en_ff <= !slp || idle;
      evsys_clk_en_ff <= !slp || idle;
      rtc_clk_en_ff <= !slp || idle || rtc_keep;
      // Gating bits act in active and idle alike
      if (!slp || idle) begin
        per_clk_en_ff <= ~gi.prr;
      end else begin
        per_clk_en_ff <= '0;
      end
    end
  end

endmodule : smc_gate
`default_nettype wire

// ===== smc_core_model.sv
// Core model: issues the sleep instruction and holds memory programming.
// Assumes go is a one-cycle bench request on pclk.
`timescale 1ns/10ps
`default_nettype none
module smc_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic go,
  input wire logic [3:0] nvm_len,
  // Controller side
  input wire logic core_halt_ff,
  output logic sleep_exec,
  output logic nvm_busy
);
  logic sleep_ff;
  logic [3:0] nvm_cnt_ff;
  assign sleep_exec = sleep_ff;
  assign nvm_busy = (nvm_cnt_ff != 4'h0);
  // A halted core runs no code, so it only sleeps from active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_ff <= 1'b0;
    end else begin
      sleep_ff <= go & ~core_halt_ff;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_cnt_ff <= 4'h0;
    end else if (go) begin
      nvm_cnt_ff <= nvm_len;
    end else if (nvm_cnt_ff != 4'h0) begin
      nvm_cnt_ff <= nvm_cnt_ff - 4'h1;
    end
  end
endmodule : smc_core_model
`default_nettype wire

// ===== smc_ctrl_asserts.sv
// Checker for the sleep mode controller top.
// Assumes ce is held high by the surroundings.
`timescale 1ns/10ps
`default_nettype none
module smc_ctrl_asserts
  import smc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  // Core side
  input wire logic sleep_exec,
  input wire logic nvm_busy,
  input wire logic rst_src_req,
  input wire logic core_halt_ff,
  input wire logic irq_resume_ff,
  input wire logic sys_rst_ff,
  // Clock enables
  input wire logic cpu_clk_en_ff,
  input wire logic nvm_clk_en_ff,
  input wire logic intc_clk_en_ff,
  input wire logic evsys_clk_en_ff,
  input wire logic rtc_clk_en_ff,
  input wire logic [SMC_NPER-1:0] per_clk_en_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------
  // Sequences
  // --------
  sequence apb_req;
    psel && penable && !pready_ff;
  endsequence
  // Clocks come back one cycle into the halt, three halted cycles remain
  sequence halt_tail;
    core_halt_ff [*3] ##1 !core_halt_ff;
  endsequence
  apb_wait_a: assert property (apb_req |=> pready_ff)
    else $error("no ready after access phase");
  apb_pulse_a: assert property (pready_ff |=> !pready_ff)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  halt_four_a: assert property ($rose(cpu_clk_en_ff) && !sys_rst_ff |-> halt_tail)
    else $error("wrong halt length");
  resume_end_a: assert property (irq_resume_ff |-> $fell(core_halt_ff) && !sys_rst_ff)
    else $error("resume pulse misplaced");
  sleep_only_a: assert property ($rose(core_halt_ff) |-> $past(sleep_exec) || sys_rst_ff)
    else $error("halt without sleep or reset");
  nvm_drain_a: assert property ($fell(cpu_clk_en_ff) |-> !$past(nvm_busy, 2))
    else $error("core clock stopped during programming");
  idle_keep_a: assert property (!cpu_clk_en_ff && intc_clk_en_ff |->
    evsys_clk_en_ff && rtc_clk_en_ff && !nvm_clk_en_ff)
    else $error("idle clock set wrong");
  deep_off_a: assert property (!intc_clk_en_ff |-> !cpu_clk_en_ff && !evsys_clk_en_ff
    && per_clk_en_ff == 8'h00)
    else $error("deep sleep clock left on");
  rst_wake_a: assert property (rst_src_req |=> sys_rst_ff && core_halt_ff)
    else $error("reset source not taken");
endmodule : smc_ctrl_asserts
bind smc_ctrl smc_ctrl_asserts u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .sleep_exec(sleep_exec), .nvm_busy(nvm_busy), .rst_src_req(rst_src_req),
  .core_halt_ff(core_halt_ff), .irq_resume_ff(irq_resume_ff), .sys_rst_ff(sys_rst_ff),
  .cpu_clk_en_ff(cpu_clk_en_ff), .nvm_clk_en_ff(nvm_clk_en_ff), .intc_clk_en_ff(intc_clk_en_ff),
  .evsys_clk_en_ff(evsys_clk_en_ff), .rtc_clk_en_ff(rtc_clk_en_ff), .per_clk_en_ff(per_clk_en_ff));
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the sleep mode controller.
// Assumes the core model and APB master below are the only drivers.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import smc_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, go = 0, er;
  logic [7:0] paddr = 0, per_clk_en_ff, prr;
  logic [31:0] pwdata = 0, prdata_ff, rd;
  logic pready_ff, pslverr_ff, sleep_exec, nvm_busy, core_halt_ff, irq_resume_ff, sys_rst_ff;
  logic irq_any = 0, async_pin_irq = 0, twi_match_irq = 0, rtc_irq = 0, rst_src_req = 0;
  logic cpu_clk_en_ff, nvm_clk_en_ff, intc_clk_en_ff, evsys_clk_en_ff, rtc_clk_en_ff;
  logic [3:0] nvm_len = 4'h3;
  logic [15:0] lfsr = 16'h0054;
  logic [2:0] md [5] = '{SMC_MODE_IDLE, SMC_MODE_PDOWN, SMC_MODE_PSAVE, SMC_MODE_STDBY, SMC_MODE_ESTDBY};
  // Sources as {irq_any, async, twi, rtc}: one that wakes, ones that must not
  logic [3:0] wk [5] = '{4'h8, 4'h2, 4'h1, 4'h4, 4'h1};
  logic [3:0] bad [5] = '{4'h0, 4'h9, 4'h8, 4'h9, 4'h8};
  int miscompares = 0, checked = 0, resumes = 0;
  always #4 pclk = ~pclk;
  smc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .sleep_exec(sleep_exec), .nvm_busy(nvm_busy), .core_halt_ff(core_halt_ff), .irq_resume_ff(irq_resume_ff),
    .sys_rst_ff(sys_rst_ff), .irq_any(irq_any), .async_pin_irq(async_pin_irq), .twi_match_irq(twi_match_irq),
    .rtc_irq(rtc_irq), .rst_src_req(rst_src_req), .cpu_clk_en_ff(cpu_clk_en_ff), .nvm_clk_en_ff(nvm_clk_en_ff),
    .intc_clk_en_ff(intc_clk_en_ff), .evsys_clk_en_ff(evsys_clk_en_ff), .rtc_clk_en_ff(rtc_clk_en_ff),
    .per_clk_en_ff(per_clk_en_ff));
  smc_core_model u_core (.pclk(pclk), .presetn(presetn), .go(go), .nvm_len(nvm_len),
    .core_halt_ff(core_halt_ff), .sleep_exec(sleep_exec), .nvm_busy(nvm_busy));
  always @(posedge pclk) if (irq_resume_ff === 1'b1) resumes++;
  function logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd
  function logic [12:0] exp_en(logic [2:0] m, logic [7:0] p);
    case (m)
      SMC_MODE_IDLE: return {5'h07, ~p};
      SMC_MODE_PSAVE, SMC_MODE_ESTDBY: return {5'h01, 8'h00};
      default: return 13'h0000;
    endcase
  endfunction : exp_en
  task end_sim();
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready_ff !== 1'b1);
    rd = prdata_ff;
    er = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_until(logic [1:0] want);
    int n;
    n = 0;
    while ({core_halt_ff, cpu_clk_en_ff} !== want && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("halt/clk", {core_halt_ff, cpu_clk_en_ff}, want);
  endtask : wait_until
  task sleep_go(logic [2:0] m, logic sen);
    apb(1'b1, SMC_CTRL_OFF, {28'h0, m, sen});
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask : sleep_go
  initial begin
    #400000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rst en", {cpu_clk_en_ff, nvm_clk_en_ff, intc_clk_en_ff, evsys_clk_en_ff,
      rtc_clk_en_ff, per_clk_en_ff}, 13'h1FFF);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("rst val", rd, 32'h0);
      chk("rst err", er, i == 4);
    end
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk("unmapped", er, 1'b1);
    for (int i = 0; i < 5; i++) begin
      prr = rnd();
      apb(1'b1, SMC_PRR_OFF, {24'h0, prr});
      apb(1'b0, SMC_PRR_OFF, 32'h0);
      chk("prr", rd, {24'h0, prr});
      chk("per act", per_clk_en_ff, {24'h0, ~prr});
      sleep_go(md[i], 1'b1);
      wait_until(2'b10);
      @(posedge pclk);
      chk("sleep en", {cpu_clk_en_ff, nvm_clk_en_ff, intc_clk_en_ff, evsys_clk_en_ff,
        rtc_clk_en_ff, per_clk_en_ff}, exp_en(md[i], prr));
      {irq_any, async_pin_irq, twi_match_irq, rtc_irq} <= bad[i];
      repeat (6) @(posedge pclk);
      chk("no wake", {core_halt_ff, cpu_clk_en_ff}, 2'h2);
      {irq_any, async_pin_irq, twi_match_irq, rtc_irq} <= wk[i];
      wait_until(2'b01);
      {irq_any, async_pin_irq, twi_match_irq, rtc_irq} <= 4'h0;
      apb(1'b0, SMC_STAT_OFF, 32'h0);
      chk("status", rd, {21'h0, md[i], 8'h10});
      apb(1'b0, SMC_WCNT_OFF, 32'h0);
      chk("wakes", rd, i + 1);
      chk("resume", resumes, i + 1);
      apb(1'b0, SMC_PRR_OFF, 32'h0);
      chk("prr kept", rd, {24'h0, prr});
    end
    for (int i = 0; i < 3; i++) begin
      sleep_go(i == 0 ? 3'h0 : (i == 1 ? 3'h4 : SMC_MODE_IDLE), i != 2);
      repeat (4) @(posedge pclk);
      chk("refused", core_halt_ff, 1'b0);
    end
    apb(1'b1, SMC_PRR_OFF, {24'h0, rnd()});
    sleep_go(SMC_MODE_PDOWN, 1'b1);
    wait_until(2'b10);
    rst_src_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("sys rst", sys_rst_ff, 1'b1);
    rst_src_req <= 1'b0;
    wait_until(2'b01);
    apb(1'b0, SMC_CTRL_OFF, 32'h0);
    chk("ctrl clr", rd, 32'h0);
    apb(1'b0, SMC_PRR_OFF, 32'h0);
    chk("prr clr", rd, 32'h0);
    apb(1'b0, SMC_STAT_OFF, 32'h0);
    chk("rst flag", {rd[12], rd[5:4]}, {1'b1, SMC_CAUSE_RST});
    apb(1'b1, SMC_STAT_OFF, 32'h0000_1000);
    apb(1'b0, SMC_STAT_OFF, 32'h0);
    chk("flag clr", rd[12], 1'b0);
    chk("no resume", resumes, 5);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
